// ==== rtl/lsd_pkg.sv ====
package lsd_pkg;
	// Blink timebase: 4 flashes per second, half period 125 ms
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned BLINK_HALF_NS  = 125_000_000;
	localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
	localparam int unsigned TB_W           = 24;

	localparam int unsigned N_CU  = 8;
	localparam int unsigned N_SFP = 6;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_LAMP = 8'h0c;

	localparam int unsigned ROLE_W   = 8;
	localparam int unsigned EV_W     = 4;
	localparam int unsigned LAMP_W   = 5;
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [3:0]  MASK_RST = 4'h0;

	// Event bit positions in status and mask
	localparam int unsigned EV_FAULT = 0;
	localparam int unsigned EV_SUP1  = 1;
	localparam int unsigned EV_SUP2  = 2;
	localparam int unsigned EV_REDUN = 3;

	localparam logic [1:0] SPD_10   = 2'h0;
	localparam logic [1:0] SPD_100  = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	localparam logic [1:0] SPD_2500 = 2'h3;

	localparam logic [1:0] ROT_FAULT  = 2'h0;
	localparam logic [1:0] ROT_LEADER = 2'h1;
	localparam logic [1:0] ROT_CPL    = 2'h2;

	// Software-set roles, low byte of the control register
	typedef struct packed {
		logic xfer;
		logic couple;
		logic tail;
		logic chain_member;
		logic ring_member;
		logic root;
		logic head;
		logic master;
	} lsd_role_t;

	typedef struct packed {
		logic sysinfo_fail;
		logic cfg_mem_err;
		logic relay;
		logic rate_shut;
		logic ring_bad;
	} lsd_fault_src_t;

	typedef struct packed {
		logic ring_down;
		logic chain_down;
		logic ring_port_down;
		logic head_port_down;
		logic tail_port_down;
	} lsd_redund_t;

	typedef struct packed {
		logic       active;
		logic       link;
		logic [1:0] speed;
		logic       tx;
	} lsd_port_t;

	typedef struct packed {
		logic fault;
		logic supply_one_lamp;
		logic supply_two_lamp;
		logic ring_leader_lamp;
		logic coupler_end_lamp;
	} lsd_sys_lamp_t;
endpackage : lsd_pkg

// ==== rtl/lsd_led_driver.sv ====
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module lsd_led_driver #(
	parameter int unsigned HALF_CYC = lsd_pkg::BLINK_HALF_CYC
) (
	input  wire logic                         mclk_i,
	input  wire logic                         rst_b_i,
	input  wire logic                         psel_i,
	input  wire logic                         penable_i,
	input  wire logic                         pwrite_i,
	input  wire logic [7:0]                   paddr_i,
	input  wire logic [31:0]                  pwdata_i,
	output logic      [31:0]                  prdata_o,
	output logic                              pready_o,
	output logic                              pslverr_o,
	input  wire lsd_pkg::lsd_fault_src_t      fault_src_i,
	input  wire logic [1:0]                   power_input_i,
	input  wire lsd_pkg::lsd_redund_t         redund_i,
	input  wire lsd_pkg::lsd_port_t [7:0]     cu_port_i,
	input  wire lsd_pkg::lsd_port_t [5:0]     sfp_port_i,
	output lsd_pkg::lsd_sys_lamp_t            sys_lamp_o,
	output logic      [7:0]                   cu_up_lamp_o,
	output logic      [7:0]                   cu_lo_lamp_o,
	output logic      [5:0]                   sfp_grn_lamp_o,
	output logic      [5:0]                   sfp_amb_lamp_o,
	output logic                              irq_o
);
	import lsd_pkg::*;

	function automatic logic lamp_fn(input logic on, input logic blk, input logic ph);
		return blk ? ph : on;
	endfunction : lamp_fn

	// Lit only on a live link at one of two speeds; transmit turns steady into blink
	function automatic logic port_fn(input lsd_port_t p, input logic [1:0] sa,
			input logic [1:0] sb, input logic ph);
		logic up;
		up = p.active & p.link & ((p.speed == sa) | (p.speed == sb));
		return lamp_fn(up, up & p.tx, ph);
	endfunction : port_fn

	logic [TB_W-1:0]     tb_cnt;
	logic [TB_W-1:0]     next_tb_cnt;
	logic                blink_ph;
	logic                next_blink_ph;
	logic                tick;

	lsd_role_t           role;
	lsd_role_t           next_role;
	logic [EV_W-1:0]     stat;
	logic [EV_W-1:0]     next_stat;
	logic [EV_W-1:0]     mask;
	logic [EV_W-1:0]     next_mask;
	logic [EV_W-1:0]     prev;
	logic [EV_W-1:0]     next_prev;
	logic [EV_W-1:0]     ev;
	logic [1:0]          rot;
	logic [1:0]          next_rot;
	logic                live;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;
	logic                next_irq;
	lsd_sys_lamp_t       next_sys;
	logic [7:0]          next_cu_up;
	logic [7:0]          next_cu_lo;
	logic [5:0]          next_sfp_grn;
	logic [5:0]          next_sfp_amb;

	logic                boot_fail;
	logic                ev_fault;
	logic                leader_on;
	logic                leader_blk;
	logic                cpl_on;
	logic                cpl_blk;
	logic                acc;
	logic                wr;
	logic                mapped;

	// Timebase: every blinking lamp reads the same phase, so they stay in step
	always_comb begin
		tick          = (tb_cnt == TB_W'(HALF_CYC - 1));
		next_tb_cnt   = tick ? '0 : tb_cnt + TB_W'(1);
		next_blink_ph = tick ? ~blink_ph : blink_ph;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			tb_cnt   <= '0;
			blink_ph <= 1'b0;
		end else begin
			tb_cnt   <= next_tb_cnt;
			blink_ph <= next_blink_ph;
		end
	end

	always_comb begin
		boot_fail  = fault_src_i.sysinfo_fail | fault_src_i.cfg_mem_err;
		ev_fault   = fault_src_i.relay | fault_src_i.rate_shut
			| fault_src_i.ring_bad;
		leader_on  = role.master | role.head | role.root;
		leader_blk = (role.master & redund_i.ring_down)
			| (role.head & redund_i.chain_down)
			| (role.ring_member & redund_i.ring_port_down)
			| ((role.chain_member | role.tail) & redund_i.head_port_down);
		cpl_on     = role.couple | role.tail;
		// Blink only while a coupler or tail role is enabled, so outside xfer rotation the lamp stays dark otherwise
		cpl_blk    = cpl_on & ((role.tail & redund_i.chain_down)
			| ((role.chain_member | role.head) & redund_i.tail_port_down));

		acc    = psel_i & penable_i;
		wr     = acc & pready_o & pwrite_i;
		mapped = (paddr_i == OFS_CTRL) | (paddr_i == OFS_STAT)
			| (paddr_i == OFS_MASK) | (paddr_i == OFS_LAMP);

		// One wait state: pready rises in the second access cycle
		next_pready  = acc & ~pready_o;
		next_pslverr = acc & ~pready_o & ~mapped;
		next_prdata  = prdata_o;
		if (acc && !pready_o) begin
			case (paddr_i)
				OFS_CTRL: next_prdata = {24'h0, role};
				OFS_STAT: next_prdata = {28'h0, stat};
				OFS_MASK: next_prdata = {28'h0, mask};
				OFS_LAMP: next_prdata = {27'h0, sys_lamp_o};
				default:  next_prdata = 32'h0;
			endcase
		end

		next_role = role;
		next_mask = mask;
		if (wr && paddr_i == OFS_CTRL) begin
			next_role = lsd_role_t'(pwdata_i[ROLE_W-1:0]);
		end
		if (wr && paddr_i == OFS_MASK) begin
			next_mask = pwdata_i[EV_W-1:0];
		end

		next_prev           = prev;
		next_prev[EV_FAULT] = boot_fail | ev_fault;
		next_prev[EV_SUP1]  = power_input_i[0];
		next_prev[EV_SUP2]  = power_input_i[1];
		next_prev[EV_REDUN] = leader_blk | cpl_blk;
		ev                  = '0;
		ev[EV_FAULT]        = next_prev[EV_FAULT] & ~prev[EV_FAULT];
		ev[EV_SUP1]         = next_prev[EV_SUP1] ^ prev[EV_SUP1];
		ev[EV_SUP2]         = next_prev[EV_SUP2] ^ prev[EV_SUP2];
		ev[EV_REDUN]        = next_prev[EV_REDUN] & ~prev[EV_REDUN];
		// New events are ORed in after the clear so a same-cycle event survives
		next_stat = stat;
		if (wr && paddr_i == OFS_STAT) begin
			next_stat = stat & ~pwdata_i[EV_W-1:0];
		end
		next_stat = next_stat | ev;
		next_irq  = |(next_stat & next_mask);

		// Rotation walks fault, leader, coupler one at a time per half period
		next_rot = '0;
		if (role.xfer) begin
			next_rot = tick ? ((rot == ROT_CPL) ? ROT_FAULT : rot + 2'h1) : rot;
		end

		next_sys.supply_one_lamp = power_input_i[0];
		next_sys.supply_two_lamp = power_input_i[1];
		if (role.xfer) begin
			next_sys.fault            = (rot == ROT_FAULT);
			next_sys.ring_leader_lamp = (rot == ROT_LEADER);
			next_sys.coupler_end_lamp = (rot == ROT_CPL);
		end else begin
			next_sys.fault            = boot_fail | ev_fault;
			next_sys.ring_leader_lamp = lamp_fn(leader_on, leader_blk, blink_ph);
			next_sys.coupler_end_lamp = lamp_fn(cpl_on, cpl_blk, blink_ph);
		end

		for (int i = 0; i < N_CU; i++) begin
			next_cu_up[i] = port_fn(cu_port_i[i], SPD_1000, SPD_1000, blink_ph);
			next_cu_lo[i] = port_fn(cu_port_i[i], SPD_10, SPD_100, blink_ph);
		end
		for (int i = 0; i < N_SFP; i++) begin
			next_sfp_grn[i] = port_fn(sfp_port_i[i], SPD_2500, SPD_2500, blink_ph);
			next_sfp_amb[i] = port_fn(sfp_port_i[i], SPD_1000, SPD_1000, blink_ph);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			role           <= lsd_role_t'(CTRL_RST);
			mask           <= MASK_RST;
			stat           <= '0;
			prev           <= '0;
			rot            <= ROT_FAULT;
			live           <= 1'b0;
			prdata_o       <= 32'h0;
			pready_o       <= 1'b0;
			pslverr_o      <= 1'b0;
			irq_o          <= 1'b0;
			sys_lamp_o     <= '0;
			cu_up_lamp_o   <= '0;
			cu_lo_lamp_o   <= '0;
			sfp_grn_lamp_o <= '0;
			sfp_amb_lamp_o <= '0;
		end else begin
			role           <= next_role;
			mask           <= next_mask;
			stat           <= next_stat;
			prev           <= next_prev;
			rot            <= next_rot;
			live           <= 1'b1;
			prdata_o       <= next_prdata;
			pready_o       <= next_pready;
			pslverr_o      <= next_pslverr;
			irq_o          <= next_irq;
			sys_lamp_o     <= next_sys;
			cu_up_lamp_o   <= next_cu_up;
			cu_lo_lamp_o   <= next_cu_lo;
			sfp_grn_lamp_o <= next_sfp_grn;
			sfp_amb_lamp_o <= next_sfp_amb;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	boot_fault_a: assert property (live && !$past(role.xfer) && $past(boot_fail)
		|-> sys_lamp_o.fault) else $error("boot failure did not light fault lamp");
	event_fault_a: assert property (live && !$past(role.xfer) && $past(ev_fault)
		|-> sys_lamp_o.fault) else $error("fault event did not light fault lamp");
	fault_dark_a: assert property (live
		&& !$past(role.xfer | boot_fail | ev_fault) |-> !sys_lamp_o.fault)
		else $error("fault lamp lit without cause");
	supply_a: assert property (live |->
		sys_lamp_o.supply_one_lamp == $past(power_input_i[0])
		&& sys_lamp_o.supply_two_lamp == $past(power_input_i[1]))
		else $error("supply lamp does not follow power input");
	leader_steady_a: assert property (live
		&& $past(!role.xfer && !leader_blk) |-> sys_lamp_o.ring_leader_lamp == $past(leader_on))
		else $error("leader lamp steady state wrong");
	leader_blink_a: assert property (live && $past(!role.xfer && leader_blk)
		|-> sys_lamp_o.ring_leader_lamp == $past(blink_ph))
		else $error("leader lamp not blinking");
	coupler_a: assert property (live && $past(!role.xfer && cpl_on)
		|-> sys_lamp_o.coupler_end_lamp == ($past(cpl_blk) ? $past(blink_ph) : 1'b1))
		else $error("coupler lamp state wrong");
	coupler_dark_a: assert property (live
		&& $past(!role.xfer && !role.couple && !role.tail) |-> !sys_lamp_o.coupler_end_lamp)
		else $error("coupler lamp lit with roles off");
	rotate_a: assert property (live && $past(role.xfer)
		|-> $onehot({sys_lamp_o.fault, sys_lamp_o.ring_leader_lamp, sys_lamp_o.coupler_end_lamp}))
		else $error("rotation not one lamp at a time");
	copper_up_a: assert property (live && $past(cu_port_i[0].active && cu_port_i[0].link
		&& cu_port_i[0].speed == SPD_1000)
		|-> cu_up_lamp_o[0] == ($past(cu_port_i[0].tx) ? $past(blink_ph) : 1'b1))
		else $error("copper upper lamp wrong");
	copper_lo_a: assert property (live && $past(cu_port_i[0].active && cu_port_i[0].link
		&& cu_port_i[0].speed == SPD_100 && !cu_port_i[0].tx) |-> cu_lo_lamp_o[0])
		else $error("copper lower lamp dark on 100 link");
	sfp_grn_a: assert property (live && $past(sfp_port_i[0].active && sfp_port_i[0].link
		&& sfp_port_i[0].speed == SPD_2500) |-> !sfp_amb_lamp_o[0]
		&& sfp_grn_lamp_o[0] == ($past(sfp_port_i[0].tx) ? $past(blink_ph) : 1'b1))
		else $error("optical green lamp wrong");
	sfp_amb_a: assert property (live && $past(sfp_port_i[0].active && sfp_port_i[0].link
		&& sfp_port_i[0].speed == SPD_1000 && !sfp_port_i[0].tx) |-> sfp_amb_lamp_o[0])
		else $error("optical amber lamp dark on 1000 link");
	port_dark_a: assert property (live && !$past(cu_port_i[0].link && cu_port_i[0].active)
		|-> !cu_up_lamp_o[0] && !cu_lo_lamp_o[0]) else $error("port lamp lit on dead link");
	blink_duty_a: assert property (!tick |=> $stable(blink_ph)
		&& tb_cnt < TB_W'(HALF_CYC)) else $error("blink phase moved early");
	blink_prio_a: assert property (live && $past(!role.xfer && leader_blk && !blink_ph)
		|-> !sys_lamp_o.ring_leader_lamp) else $error("steady beat blinking");
	irq_level_a: assert property (live |-> irq_o == |($past(next_stat & next_mask)))
		else $error("interrupt level wrong");

	rotate_c: cover property (role.xfer && tick ##1 role.xfer[*2]);
	leader_blink_c: cover property (leader_blk && tick);
	irq_c: cover property ($rose(irq_o));
	apb_err_c: cover property (pslverr_o && pready_o);
endmodule : lsd_led_driver

// ==== tb/lsd_src_model.sv ====
`timescale 1ns/1ns
// Status sources facing the lamp driver; every source is a level that holds until changed
module lsd_src_model (
	input  wire logic                    mclk_i,
	output lsd_pkg::lsd_fault_src_t      fault_src_o,
	output logic [1:0]                   power_input_o,
	output lsd_pkg::lsd_redund_t         redund_o,
	output lsd_pkg::lsd_port_t [7:0]     cu_port_o,
	output lsd_pkg::lsd_port_t [5:0]     sfp_port_o
);
	import lsd_pkg::*;
	initial begin
		fault_src_o = '0;
		power_input_o = 2'h0;
		redund_o = '0;
		cu_port_o = '0;
		sfp_port_o = '0;
	end
	// Changes land just after a rising edge so the driver samples them one edge later
	task apply(input lsd_fault_src_t f, input logic [1:0] p, input lsd_redund_t r,
		input lsd_port_t c, input lsd_port_t s);
		@(posedge mclk_i);
		fault_src_o <= f;
		power_input_o <= p;
		redund_o <= r;
		cu_port_o <= {8{c}};
		sfp_port_o <= {6{s}};
	endtask : apply
endmodule : lsd_src_model

// ==== tb/lsd_led_driver_bench.sv ====
`timescale 1ns/1ns
module lsd_led_driver_bench;
	import lsd_pkg::*;
	localparam int H = 8;
	logic                 mclk_i = 1'b0;
	logic                 rst_b_i = 1'b0;
	logic                 psel = 1'b0;
	logic                 pen = 1'b0;
	logic                 power_input = 1'b0;
	logic [7:0]           pa = 8'h00;
	logic [31:0]          pwd = 32'h0;
	logic [31:0]          prd;
	logic [31:0]          rd;
	logic                 prdy;
	logic                 perr;
	logic                 er;
	logic                 irq;
	lsd_fault_src_t       fs;
	logic [1:0]           pw;
	lsd_redund_t          rdn;
	lsd_port_t [7:0]      cu;
	lsd_port_t [5:0]      sf;
	lsd_sys_lamp_t        sl;
	logic [7:0]           cuu;
	logic [7:0]           cul;
	logic [5:0]           sg;
	logic [5:0]           sa;
	lsd_fault_src_t       tf = '0;
	logic [1:0]           tp = 2'h0;
	lsd_redund_t          tr = '0;
	lsd_port_t            tc = '0;
	int                   miscompares = 0;
	int                   total_checks = 0;
	logic [7:0]           roles [5] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20};
	logic [4:0]           reds [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02};
	int                   sels [4] = '{2, 2, 3, 1};

	always #4 mclk_i = ~mclk_i;

	lsd_src_model lsd_src_model_inst (.mclk_i(mclk_i), .fault_src_o(fs), .power_input_o(pw),
		.redund_o(rdn), .cu_port_o(cu), .sfp_port_o(sf));

	lsd_led_driver #(.HALF_CYC(H)) lsd_led_driver_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(power_input), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .fault_src_i(fs),
		.power_input_i(pw), .redund_i(rdn), .cu_port_i(cu), .sfp_port_i(sf),
		.sys_lamp_o(sl), .cu_up_lamp_o(cuu), .cu_lo_lamp_o(cul), .sfp_grn_lamp_o(sg),
		.sfp_amb_lamp_o(sa), .irq_o(irq));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Ready and read data are taken at the rising edge that samples ready high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pen <= 1'b0;
		power_input <= w;
		pa <= a;
		pwd <= d;
		@(posedge mclk_i);
		pen <= 1'b1;
		@(posedge mclk_i);
		while (prdy !== 1'b1 && n < 50) begin
			@(posedge mclk_i);
			n++;
		end
		if (n == 50)
			miscompares++;
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task go;
		lsd_src_model_inst.apply(tf, tp, tr, tc, tc);
		repeat (2) @(negedge mclk_i);
	endtask : go

	function automatic logic lamp(input int s);
		logic [8:0] all;
		all = {sl, cuu[0], cul[0], sg[0], sa[0]};
		return all[s];
	endfunction : lamp

	// Counting lit cycles over whole periods makes the check independent of blink phase
	task blink(input int s, input int win, input int exp);
		int c;
		c = 0;
		repeat (win) begin
			@(negedge mclk_i);
			if (lamp(s) === 1'b1)
				c++;
		end
		check(c, exp);
	endtask : blink

	initial begin
		#(20000 * 8);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(negedge mclk_i);
		check({sl, cuu, cul, sg, sa, irq}, 0);
		apb(0, OFS_CTRL, 0);
		check(rd, CTRL_RST);
		apb(0, OFS_MASK, 0);
		check(rd, MASK_RST);
		apb(0, 8'h40, 0);
		check({er, rd}, {1'b1, 32'h0});
		for (int i = 0; i < 5; i++) begin
			tf = 5'h01 << i;
			go();
			check(sl.fault, 1);
		end
		tf = '0;
		go();
		check(sl.fault, 0);
		for (int i = 0; i < 4; i++) begin
			tp = 2'(i);
			go();
			check({sl.supply_one_lamp, sl.supply_two_lamp}, {tp[0], tp[1]});
		end
		apb(1, OFS_STAT, 32'hf);
		apb(0, OFS_STAT, 0);
		check(rd, 0);
		tf.relay = 1'b1;
		go();
		apb(0, OFS_STAT, 0);
		check(rd, 32'h1);
		check(irq, 0);
		apb(1, OFS_MASK, 32'h1);
		repeat (2) @(negedge mclk_i);
		check(irq, 1);
		apb(1, OFS_STAT, 32'h9);
		repeat (2) @(negedge mclk_i);
		check(irq, 0);
		apb(0, OFS_LAMP, 0);
		check(rd, 32'h1c);
		apb(1, OFS_LAMP, 32'hff);
		check(er, 0);
		apb(0, OFS_LAMP, 0);
		check(rd, 32'h1c);
		tf = '0;
		tp = 2'h0;
		for (int i = 0; i < 4; i++) begin
			apb(1, OFS_CTRL, (i == 3) ? 32'h0 : (32'h1 << i));
			go();
			check(sl.ring_leader_lamp, i != 3);
		end
		for (int i = 0; i < 5; i++) begin
			apb(1, OFS_CTRL, roles[i] | 8'h01);
			tr = reds[i];
			go();
			blink(5, 2 * H, H);
		end
		tr = '0;
		apb(1, OFS_CTRL, 32'h40);
		go();
		check(sl.coupler_end_lamp, 1);
		apb(1, OFS_CTRL, 32'h20);
		go();
		check(sl.coupler_end_lamp, 1);
		tr.chain_down = 1'b1;
		go();
		blink(4, 2 * H, H);
		apb(1, OFS_CTRL, 32'h0);
		repeat (2) @(negedge mclk_i);
		check(sl.coupler_end_lamp, 0);
		tr = '0;
		tp = 2'h3;
		apb(1, OFS_CTRL, 32'h80);
		go();
		for (int s = 4; s < 9; s++) begin
			if (s == 6)
				s = 8;
			blink(s, 3 * H, H);
		end
		check({sl.supply_one_lamp, sl.supply_two_lamp}, 2'h3);
		apb(1, OFS_CTRL, 32'h0);
		for (int sp = 0; sp < 4; sp++) begin
			tc = {1'b1, 1'b1, 2'(sp), 1'b0};
			go();
			check({cuu, cul, sg, sa}, {(sp == 2) ? 8'hff : 8'h00, (sp < 2) ? 8'hff : 8'h00,
				(sp == 3) ? 6'h3f : 6'h00, (sp == 2) ? 6'h3f : 6'h00});
			tc.active = 1'b0;
			go();
			check({cuu, cul, sg, sa}, 0);
			tc = {1'b1, 1'b0, 2'(sp), 1'b1};
			go();
			check({cuu, cul, sg, sa}, 0);
			tc.link = 1'b1;
			go();
			blink(sels[sp], 2 * H, H);
			if (sp == 2)
				blink(0, 2 * H, H);
		end
		tc = {1'b1, 1'b1, 2'h2, 1'b1};
		tr.ring_down = 1'b1;
		apb(1, OFS_CTRL, 32'h1);
		go();
		repeat (2 * H) begin
			@(negedge mclk_i);
			check(sl.ring_leader_lamp ^ cuu[0], 0);
		end
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(negedge mclk_i);
		check({sl, cuu, cul, sg, sa, irq}, 0);
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		apb(0, OFS_CTRL, 0);
		check(rd, CTRL_RST);
		tally_and_finish();
	end
endmodule : lsd_led_driver_bench
